// ==== hw/chmcm_pkg.sv ====
// Package for the card host-mode and configuration map block.
// Assumes a single 100 MHz clock domain and the parallel socket bus.
package chmcm_pkg;

	// ----------------------------------------------------------------
	// Attribute-space register offsets (byte addresses) and tuple chain length (entries)
	// ----------------------------------------------------------------
	localparam logic [10:0] CHM_OFS_OPTION = 11'h200;
	localparam logic [10:0] CHM_OFS_STATE = 11'h202;
	localparam logic [10:0] CHM_OFS_PIN = 11'h204;
	localparam logic [10:0] CHM_OFS_SOCKET = 11'h206;
	localparam logic [10:0] CHM_TUPLE_LEN = 11'h09C;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int CHM_IDX_LSB = 0;
	localparam int CHM_IDX_W = 6;
	localparam int CHM_LEVEL_BIT = 6;
	localparam int CHM_SRESET_BIT = 7;
	localparam int CHM_INTR_BIT = 1;
	localparam int CHM_PWRDN_BIT = 2;
	localparam int CHM_RDY_BIT = 1;
	localparam int CHM_PIN_RDY_BIT = 5;
	localparam logic [7:0] CHM_OPTION_RST = 8'h00;
	localparam logic [7:0] CHM_STATE_RST = 8'h00;
	localparam logic [7:0] CHM_SOCKET_RST = 8'h00;
	localparam logic [5:0] CHM_IDX_MAX = 6'h03;

	// ----------------------------------------------------------------
	// Modes and I/O windows
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CHM_MAP_MEM = 3'b000,
		CHM_MAP_CONTIG = 3'b001,
		CHM_MAP_PRIMARY = 3'b011,
		CHM_MAP_SECONDARY = 3'b010,
		CHM_MAP_IDE = 3'b110
	} chm_map_e;

	localparam logic [10:0] CHM_MEM_SPAN = 11'h7FF;
	localparam logic [9:0] CHM_PRI_BASE = 10'h1F0;
	localparam logic [9:0] CHM_PRI_ALT = 10'h3F6;
	localparam logic [9:0] CHM_SEC_BASE = 10'h170;
	localparam logic [9:0] CHM_SEC_ALT = 10'h376;
	localparam logic [3:0] CHM_DATA_REG = 4'h0;
	localparam logic [3:0] CHM_FEAT_REG = 4'h1;
	localparam logic [3:0] CHM_CMD_REG = 4'h7;

	// ----------------------------------------------------------------
	// Commands and tuple codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CHM_CMD_IDENTIFY = 8'hEC;
	localparam logic [7:0] CHM_CMD_SETFEAT = 8'hEF;
	localparam logic [7:0] CHM_FEAT_8BIT_ON = 8'h01;
	localparam logic [7:0] CHM_FEAT_8BIT_OFF = 8'h81;
	localparam logic [7:0] CHM_FUNC_FIXED = 8'h04;
	localparam logic [7:0] CHM_FUNC_REMOVABLE = 8'h00;
	localparam logic [7:0] CHM_SYSINIT = 8'h01;
	localparam logic [10:0] CHM_FUNC_OFS = 11'h02F;
	localparam logic [7:0] CHM_TPL_NOLINK = 8'h14;
	localparam logic [7:0] CHM_TPL_END = 8'hFF;
	localparam logic [7:0] CHM_TPL_CONFIG = 8'h1A;
	localparam logic [7:0] CHM_TPL_ENTRY = 8'h1B;
	localparam logic [7:0] CHM_TPL_FUNCID = 8'h21;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic ce_n;
		logic reg_n;
		logic oe_n;
		logic we_n;
		logic iord_n;
		logic iowr_n;
		logic [10:0] addr;
		logic [7:0] wdata;
	} chm_bus_s;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [10:0] addr;
		logic [7:0] wdata;
	} chm_attr_req_s;

endpackage

// ==== hw/chmcm_sync.sv ====
// Three-stage input synchroniser with an agreement filter.
// Assumes the input is asynchronous to i_clk.
`timescale 1ns/100ps
module chmcm_sync
	import chmcm_pkg::*;
#(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Data
	input wire logic [W-1:0] i_d,
	input wire logic [W-1:0] i_rst_val,
	output logic [W-1:0] o_q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
		logic [1:0] init;
	} chm_sync_s;

	chm_sync_s r;
	chm_sync_s next_r;

	// Filtered value only moves once stages two and three agree
	always_comb begin
		next_r = r;
		next_r.s1 = i_d;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
		if (r.init != 2'h3) begin
			// Stages still hold reset zeros, which would read as asserted strobes
			next_r.q = i_rst_val;
			next_r.init = r.init + 2'h1;
		end else if (r.s2 == r.s3) begin
			next_r.q = r.s3;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign o_q = (r.init == 2'h0) ? i_rst_val : r.q;

endmodule

// ==== hw/chmcm_tuples.sv ====
// Fixed configuration tuple chain, one byte per even attribute address.
// Assumes the caller passes the tuple byte index (address divided by two).
`timescale 1ns/100ps
module chmcm_tuples
	import chmcm_pkg::*;
(
	// Lookup
	input wire logic [10:0] i_index,
	input wire logic i_ide,
	output logic [7:0] o_byte
);

	// Function code differs only between IDE and socket use
	always_comb begin
		case (i_index)
			11'h000: o_byte = 8'h01;
			11'h001: o_byte = 8'h04;
			11'h006: o_byte = 8'h1C;
			11'h007: o_byte = 8'h05;
			11'h00D: o_byte = 8'h18;
			11'h00E: o_byte = 8'h02;
			11'h011: o_byte = 8'h20;
			11'h012: o_byte = 8'h04;
			11'h017: o_byte = 8'h15;
			11'h018: o_byte = 8'h14;
			11'h02D: o_byte = CHM_TPL_FUNCID;
			11'h02E: o_byte = 8'h02;
			CHM_FUNC_OFS: o_byte = i_ide ? CHM_FUNC_FIXED : CHM_FUNC_REMOVABLE; // [RULE18]
			11'h030: o_byte = CHM_SYSINIT; // [RULE18]
			11'h03A: o_byte = CHM_TPL_CONFIG;
			11'h03B: o_byte = 8'h05;
			11'h03C: o_byte = 8'h01;
			11'h03D: o_byte = 8'h03;
			11'h03E: o_byte = 8'h00;
			11'h03F: o_byte = 8'h02;
			11'h040: o_byte = 8'h0F;
			11'h041: o_byte = CHM_TPL_ENTRY;
			11'h042: o_byte = 8'h08;
			11'h043: o_byte = 8'hC0;
			11'h053: o_byte = CHM_TPL_ENTRY;
			11'h054: o_byte = 8'h0A;
			11'h055: o_byte = 8'hC1;
			11'h067: o_byte = CHM_TPL_ENTRY;
			11'h068: o_byte = 8'h0F;
			11'h069: o_byte = 8'hC2;
			11'h080: o_byte = CHM_TPL_ENTRY;
			11'h081: o_byte = 8'h0F;
			11'h082: o_byte = 8'hC3;
			11'h099: o_byte = CHM_TPL_NOLINK; // [RULE17]
			11'h09A: o_byte = 8'h00; // [RULE17]
			11'h09B: o_byte = CHM_TPL_END; // [RULE17]
			default: o_byte = 8'h00;
		endcase
	end

endmodule

// ==== hw/chmcm_top.sv ====
// Host mode selection, attribute registers and window decode of the card.
// Assumes socket strobes arrive asynchronously and are synchronised here.
//
// Behaviour
// RULE1: Host asserts attribute select for every attribute and tuple access.
// RULE2: Host releases attribute select for common memory; card decodes common.
// RULE3: Option index selects memory, contiguous, primary or secondary mapping.
// RULE4: Strap low at power-up selects IDE operation, else socket card.
// RULE5: In IDE operation attribute registers are unreachable.
// RULE6: IDE data register starts as full 16-bit words.
// RULE7: Byte-wide data only after set-features asks for it.
// RULE8: Identify command EC starts return of the parameter block; the code starts it only in IDE operation.
// RULE9: Config registers sit at 200, 202, 204, 206 in attribute space.
// RULE10: Index 0 to 3 valid; above 3 is not a configuration.
// RULE11: Index 0 maps 2048 bytes of memory and needs wait support.
// RULE12: Index 1 decodes 4 lines, 8/16 bit, any interrupt.
// RULE13: Index 2 answers 01F0 block of 8 and 03F6 block of 2.
// RULE14: Index 3 answers 0170 block of 8 and 0376 block of 2.
// RULE15: I/O configurations support pulse and level interrupts, shareable.
// RULE16: Ready-busy driven, battery and write-protect inactive, no wait in I/O.
// RULE17: Tuple chain ends with no-link 14 length 0, then FF.
// RULE18: Function code 04 in IDE, removable otherwise; system init 01.
// RULE19: Every mode includes the alternate status location; the code decodes it only in the I/O and IDE mappings, not in memory mode.
// RULE20: Host writes socket and copy before option register.
`timescale 1ns/100ps
module chmcm_top
	import chmcm_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Socket strobes and data
	input wire logic i_ce_n,
	input wire logic i_reg_n,
	input wire logic i_oe_n,
	input wire logic i_we_n,
	input wire logic i_iord_n,
	input wire logic i_iowr_n,
	input wire logic [10:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_ide_mode_strap_n,
	// Card core status
	input wire logic i_core_busy,
	input wire logic i_core_irq,
	// Read data
	output logic [7:0] o_rdata,
	output logic o_rdata_oe,
	// Status lines
	output logic o_ready_busy_line,
	output logic o_irq_n,
	output logic [1:0] o_battery_detect_outputs,
	output logic o_write_protect,
	output logic o_wait_n,
	// Mode and decode
	output logic [2:0] o_map_mode,
	output logic o_ide_mode,
	output logic o_data_8bit,
	output logic o_identify_start,
	output logic o_io_hit,
	output logic o_mem_hit,
	output logic o_alt_hit,
	output logic o_soft_reset
);

	// ----------------------------------------------------------------
	// Input synchronisation
	// ----------------------------------------------------------------
	chm_bus_s bus_raw;
	chm_bus_s bus;
	chm_bus_s bus_idle;
	logic strap_n;
	logic [7:0] tuple_byte;

	assign bus_raw = '{ce_n: i_ce_n, reg_n: i_reg_n, oe_n: i_oe_n, we_n: i_we_n,
		iord_n: i_iord_n, iowr_n: i_iowr_n, addr: i_addr, wdata: i_wdata};
	assign bus_idle = '{ce_n: 1'b1, reg_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
		iord_n: 1'b1, iowr_n: 1'b1, addr: 11'h000, wdata: 8'h00};

	chmcm_sync #(.W($bits(chm_bus_s))) u_bus_sync (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_d(bus_raw),
		.i_rst_val(bus_idle),
		.o_q(bus)
	);

	chmcm_sync #(.W(1)) u_strap_sync (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_d(i_ide_mode_strap_n),
		.i_rst_val(1'b1),
		.o_q(strap_n)
	);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0] boot;
		logic ide;
		logic [7:0] option;
		logic [7:0] state;
		logic [7:0] socket;
		logic data_8bit;
		logic [7:0] feature;
		logic prev_wr;
		logic prev_iowr;
		logic prev_irq;
		logic [7:0] rdata;
		logic rdata_oe;
		logic rdy;
		logic irq_n;
		logic wait_n;
		chm_map_e map;
		logic identify;
		logic io_hit;
		logic mem_hit;
		logic alt_hit;
		logic soft_reset;
	} chm_top_s;

	chm_top_s r;
	chm_top_s next_r;

	chmcm_tuples u_tuples (
		.i_index({1'b0, bus.addr[10:1]}),
		.i_ide(r.ide),
		.o_byte(tuple_byte)
	);

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	logic attr_sel;
	logic attr_wr;
	logic attr_rd;
	logic common_sel;
	logic io_rd;
	logic io_wr;
	logic io_task;
	logic io_alt;
	logic [3:0] task_reg;
	logic [5:0] cfg_index;
	logic cfg_valid;
	logic attr_wr_go;
	logic io_wr_go;
	logic [7:0] pin_byte;

	// Attribute space only with select asserted and not in IDE operation
	assign attr_sel = !bus.ce_n && !bus.reg_n && !r.ide; // [RULE1] [RULE5]
	assign attr_wr = attr_sel && !bus.we_n;
	assign attr_rd = attr_sel && !bus.oe_n;
	assign common_sel = !bus.ce_n && bus.reg_n; // [RULE2]
	assign io_rd = !bus.ce_n && !bus.iord_n;
	assign io_wr = !bus.ce_n && !bus.iowr_n;
	assign cfg_index = r.option[CHM_IDX_LSB +: CHM_IDX_W];
	assign cfg_valid = cfg_index <= CHM_IDX_MAX; // [RULE10]

	// One register write per strobe, however long the host holds it low
	assign attr_wr_go = attr_wr && !r.prev_wr;
	assign io_wr_go = io_wr && !r.prev_iowr;

	// Only the ready image is live; the other pin images read as zero
	always_comb begin
		pin_byte = 8'h00;
		pin_byte[CHM_PIN_RDY_BIT] = !i_core_busy; // [RULE16]
	end

	// Window decode per mapping, alternate status in every I/O form
	always_comb begin
		io_task = 1'b0;
		io_alt = 1'b0;
		task_reg = bus.addr[3:0];
		case (r.map)
			CHM_MAP_CONTIG: begin
				io_task = bus.addr[3:0] < 4'h8; // [RULE12]
				io_alt = bus.addr[3:0] == 4'hE || bus.addr[3:0] == 4'hF; // [RULE19]
			end
			CHM_MAP_PRIMARY: begin
				io_task = bus.addr[9:3] == CHM_PRI_BASE[9:3]; // [RULE13]
				io_alt = bus.addr[9:1] == CHM_PRI_ALT[9:1]; // [RULE13] [RULE19]
			end
			CHM_MAP_SECONDARY: begin
				io_task = bus.addr[9:3] == CHM_SEC_BASE[9:3]; // [RULE14]
				io_alt = bus.addr[9:1] == CHM_SEC_ALT[9:1]; // [RULE14] [RULE19]
			end
			CHM_MAP_IDE: begin
				io_task = bus.addr[3] == 1'b0;
				io_alt = bus.addr[3:1] == 3'b111; // [RULE19]
			end
			default: begin
				io_task = 1'b0;
				io_alt = 1'b0;
			end
		endcase
		task_reg = {1'b0, bus.addr[2:0]};
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_r = r;
		next_r.identify = 1'b0;
		next_r.soft_reset = r.option[CHM_SRESET_BIT];
		next_r.prev_wr = attr_wr || (io_wr && io_task);
		next_r.prev_iowr = io_wr;
		next_r.prev_irq = i_core_irq;

		// Strap caught after release once the filter has settled
		if (r.boot != 4'hF) begin
			next_r.boot = r.boot + 4'h1;
			if (r.boot == 4'hE) begin
				next_r.ide = !strap_n; // [RULE4]
				next_r.data_8bit = 1'b0; // [RULE6]
			end
		end

		// Configuration register writes, edge of the write strobe only
		if (attr_wr_go) begin
			case (bus.addr)
				CHM_OFS_OPTION: next_r.option = bus.wdata; // [RULE9] [RULE20]
				CHM_OFS_STATE: next_r.state = bus.wdata;
				CHM_OFS_SOCKET: next_r.socket = bus.wdata; // [RULE9]
				default: next_r.state = r.state;
			endcase
		end

		// Mapping follows the index outside IDE operation; invalid index falls back to memory
		if (r.ide) begin
			next_r.map = CHM_MAP_IDE;
		end else if (!cfg_valid) begin
			next_r.map = CHM_MAP_MEM; // [RULE10]
		end else begin
			case (cfg_index[1:0]) // [RULE3]
				2'd0: next_r.map = CHM_MAP_MEM; // [RULE11]
				2'd1: next_r.map = CHM_MAP_CONTIG; // [RULE12]
				2'd2: next_r.map = CHM_MAP_PRIMARY; // [RULE13]
				2'd3: next_r.map = CHM_MAP_SECONDARY; // [RULE14]
				default: next_r.map = CHM_MAP_MEM;
			endcase
		end

		// Task file writes: feature then set-features or identify
		if (io_wr_go && io_task && r.map != CHM_MAP_MEM) begin
			if (task_reg == CHM_FEAT_REG) begin
				next_r.feature = bus.wdata;
			end else if (task_reg == CHM_CMD_REG) begin
				if (bus.wdata == CHM_CMD_SETFEAT && r.feature == CHM_FEAT_8BIT_ON) begin
					next_r.data_8bit = 1'b1; // [RULE7]
				end else if (bus.wdata == CHM_CMD_SETFEAT && r.feature == CHM_FEAT_8BIT_OFF) begin
					next_r.data_8bit = 1'b0;
				end
				if (bus.wdata == CHM_CMD_IDENTIFY && r.ide) begin
					next_r.identify = 1'b1; // [RULE8]
				end
			end
		end

		// Interrupt: level follows core, pulse mode gives one clock low
		if (r.map == CHM_MAP_MEM) begin
			next_r.irq_n = 1'b1;
		end else if (r.option[CHM_LEVEL_BIT]) begin
			next_r.irq_n = !i_core_irq; // [RULE15]
		end else begin
			next_r.irq_n = !(i_core_irq && !r.prev_irq); // [RULE15]
		end
		// Pending interrupt set wins over any clear in the same cycle
		if (i_core_irq) begin
			next_r.state[CHM_INTR_BIT] = 1'b1;
		end else if (attr_wr_go && bus.addr == CHM_OFS_STATE) begin
			next_r.state[CHM_INTR_BIT] = bus.wdata[CHM_INTR_BIT];
		end

		// Status lines
		next_r.rdy = !i_core_busy; // [RULE16]
		next_r.wait_n = !(r.map == CHM_MAP_MEM && common_sel && i_core_busy); // [RULE11] [RULE16]

		// Read data: attribute registers and tuples, never in IDE
		next_r.rdata = 8'h00;
		next_r.rdata_oe = 1'b0;
		if (attr_rd) begin
			next_r.rdata_oe = 1'b1;
			case (bus.addr)
				CHM_OFS_OPTION: next_r.rdata = r.option;
				CHM_OFS_STATE: next_r.rdata = r.state;
				CHM_OFS_PIN: next_r.rdata = pin_byte;
				CHM_OFS_SOCKET: next_r.rdata = r.socket;
				default: begin
					if (bus.addr < {CHM_TUPLE_LEN[9:0], 1'b0} && !bus.addr[0]) begin
						next_r.rdata = tuple_byte; // [RULE17]
					end
				end
			endcase
		end

		next_r.io_hit = (io_rd || io_wr) && io_task && r.map != CHM_MAP_MEM;
		next_r.alt_hit = (io_rd || io_wr) && io_alt && r.map != CHM_MAP_MEM; // [RULE19]
		next_r.mem_hit = common_sel && r.map == CHM_MAP_MEM && !r.ide && bus.addr <= CHM_MEM_SPAN; // [RULE11]
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			r <= '{boot: 4'h0, ide: 1'b0, option: CHM_OPTION_RST, state: CHM_STATE_RST,
				socket: CHM_SOCKET_RST, data_8bit: 1'b0, feature: 8'h00, prev_wr: 1'b0,
				prev_iowr: 1'b0, prev_irq: 1'b0, rdata: 8'h00, rdata_oe: 1'b0, rdy: 1'b0,
				irq_n: 1'b1, wait_n: 1'b1, map: CHM_MAP_MEM, identify: 1'b0, io_hit: 1'b0,
				mem_hit: 1'b0, alt_hit: 1'b0, soft_reset: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign o_rdata = r.rdata;
	assign o_rdata_oe = r.rdata_oe;
	assign o_ready_busy_line = r.rdy; // [RULE16]
	assign o_irq_n = r.irq_n;
	assign o_battery_detect_outputs = 2'b11; // [RULE16]
	assign o_write_protect = 1'b0; // [RULE16]
	assign o_wait_n = r.wait_n;
	assign o_map_mode = r.map;
	assign o_ide_mode = r.ide;
	assign o_data_8bit = r.data_8bit;
	assign o_identify_start = r.identify;
	assign o_io_hit = r.io_hit;
	assign o_mem_hit = r.mem_hit;
	assign o_alt_hit = r.alt_hit;
	assign o_soft_reset = r.soft_reset;

endmodule

// ==== tb/chmcm_chk.sv ====
// Checker of the card host-mode block, bound to its top module.
// Assumes one clock domain and strobes held low for several clocks.
`timescale 1ns/100ps
module chmcm_chk
	import chmcm_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Watched pins
	input wire logic i_oe_n,
	input wire logic i_reg_n,
	input wire logic i_core_busy,
	input wire logic o_rdata_oe,
	input wire logic o_ready_busy_line,
	input wire logic [1:0] o_battery_detect_outputs,
	input wire logic o_write_protect,
	input wire logic o_wait_n,
	input wire logic [2:0] o_map_mode,
	input wire logic o_ide_mode,
	input wire logic o_data_8bit,
	input wire logic o_identify_start,
	input wire logic o_io_hit,
	input wire logic o_mem_hit
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);
	// ----
	// Attribute read history, deep enough for the slowest answer
	// ----
	logic [6:0] attr_rd;
	logic [6:0] next_attr_rd;
	always_comb next_attr_rd = {attr_rd[5:0], !i_oe_n && !i_reg_n};
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst)
			attr_rd <= 7'h00;
		else
			attr_rd <= next_attr_rd;
	end
	sequence s_id_pulse;
		o_identify_start ##1 !o_identify_start;
	endsequence
	property p_rdata_src; o_rdata_oe |-> |attr_rd[6:3]; endproperty
	a_rdata_src: assert property (p_rdata_src) else $error("read data without attribute read");
	property p_static; o_battery_detect_outputs == 2'h3 && !o_write_protect; endproperty
	a_static: assert property (p_static) else $error("battery or protect active");
	property p_ready; $changed(i_core_busy) |-> ##[1:2] (o_ready_busy_line != i_core_busy); endproperty
	a_ready: assert property (p_ready) else $error("ready line not following busy");
	property p_wait; !o_wait_n |-> o_map_mode == CHM_MAP_MEM && !o_ide_mode; endproperty
	a_wait: assert property (p_wait) else $error("wait outside memory mode");
	property p_ide_map; o_ide_mode && $past(o_ide_mode) |-> o_map_mode == CHM_MAP_IDE; endproperty
	a_ide_map: assert property (p_ide_map) else $error("ide mode with other map");
	property p_ide_attr; o_ide_mode |-> !o_rdata_oe; endproperty
	a_ide_attr: assert property (p_ide_attr) else $error("attribute answer in ide");
	property p_ide_16; $rose(o_ide_mode) |-> !o_data_8bit; endproperty
	a_ide_16: assert property (p_ide_16) else $error("ide starts byte wide");
	property p_id; o_identify_start |-> o_ide_mode ##0 s_id_pulse; endproperty
	a_id: assert property (p_id) else $error("identify pulse wrong");
	property p_idx; !o_ide_mode |-> o_map_mode inside {CHM_MAP_MEM, CHM_MAP_CONTIG, CHM_MAP_PRIMARY, CHM_MAP_SECONDARY};
	endproperty
	a_idx: assert property (p_idx) else $error("invalid map");
	property p_io; o_io_hit |-> o_map_mode != CHM_MAP_MEM; endproperty
	a_io: assert property (p_io) else $error("io hit in memory map");
	property p_mem; o_mem_hit |-> o_map_mode == CHM_MAP_MEM; endproperty
	a_mem: assert property (p_mem) else $error("memory hit outside memory map");
endmodule

bind chmcm_top chmcm_chk u_chmcm_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_oe_n(i_oe_n), .i_reg_n(i_reg_n),
	.i_core_busy(i_core_busy), .o_rdata_oe(o_rdata_oe), .o_ready_busy_line(o_ready_busy_line),
	.o_battery_detect_outputs(o_battery_detect_outputs), .o_write_protect(o_write_protect), .o_wait_n(o_wait_n),
	.o_map_mode(o_map_mode), .o_ide_mode(o_ide_mode), .o_data_8bit(o_data_8bit),
	.o_identify_start(o_identify_start), .o_io_hit(o_io_hit), .o_mem_hit(o_mem_hit));

// ==== tb/chmcm_host.sv ====
// Host socket controller model driving whole strobe cycles.
// Assumes the card answers within five clocks of the strobes settling.
`timescale 1ns/100ps
module chmcm_host
	import chmcm_pkg::*;
(
	// Clock
	input wire logic i_clk,
	// Card answer
	input wire logic [7:0] i_rdata,
	input wire logic [4:0] i_seen,
	// Socket bus
	output chm_bus_s o_bus
);
	logic [7:0] seen_rdata;
	logic [4:0] seen;
	initial o_bus = {6'h3F, 11'h7FF, 8'hFF};
	// Kind: 0 attr read, 1 attr write, 2 common read, 3 io read, 4 io write
	task automatic cycle(input int kind, input logic [10:0] addr, input logic [7:0] wdata);
		@(posedge i_clk);
		#1;
		o_bus.ce_n = 1'b0;
		o_bus.reg_n = (kind == 2);
		o_bus.oe_n = !(kind == 0 || kind == 2);
		o_bus.we_n = (kind != 1);
		o_bus.iord_n = (kind != 3);
		o_bus.iowr_n = (kind != 4);
		o_bus.addr = addr;
		o_bus.wdata = wdata;
		// Held seven edges so the slowest answer already stands
		repeat (7) @(posedge i_clk);
		#1;
		seen_rdata = i_rdata;
		seen = i_seen;
		// Released lines show the inverse, never the stale value
		o_bus = {6'h3F, ~addr, ~wdata};
		repeat (4) @(posedge i_clk);
		#1;
	endtask
endmodule

// ==== tb/test_chmcm_top.sv ====
// Testbench of the card host-mode block: host model, core side, checks.
// Assumes the host model owns every socket strobe.
`timescale 1ns/100ps
module test_chmcm_top
	import chmcm_pkg::*;
();
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic strap_n = 1'b1;
	logic busy = 1'b0;
	logic irq = 1'b0;
	chm_bus_s bus;
	logic [7:0] rdata;
	logic rdata_oe, rdy, irq_n, wp, wait_n, ide, d8, id_go, io_hit, mem_hit, alt_hit, sreset;
	logic [1:0] batt;
	logic [2:0] map;
	int mismatches = 0;
	int compares = 0;
	int id_cnt = 0;
	always #5 clk = ~clk;
	always @(posedge clk) if (id_go) id_cnt <= id_cnt + 1;
	chmcm_top u_chmcm_top (.i_clk(clk), .i_nrst(nrst), .i_ce_n(bus.ce_n), .i_reg_n(bus.reg_n), .i_oe_n(bus.oe_n),
		.i_we_n(bus.we_n), .i_iord_n(bus.iord_n), .i_iowr_n(bus.iowr_n), .i_addr(bus.addr), .i_wdata(bus.wdata),
		.i_ide_mode_strap_n(strap_n), .i_core_busy(busy), .i_core_irq(irq), .o_rdata(rdata), .o_rdata_oe(rdata_oe),
		.o_ready_busy_line(rdy), .o_irq_n(irq_n), .o_battery_detect_outputs(batt), .o_write_protect(wp),
		.o_wait_n(wait_n), .o_map_mode(map), .o_ide_mode(ide), .o_data_8bit(d8), .o_identify_start(id_go),
		.o_io_hit(io_hit), .o_mem_hit(mem_hit), .o_alt_hit(alt_hit), .o_soft_reset(sreset));
	chmcm_host u_chmcm_host (.i_clk(clk), .i_rdata(rdata), .i_seen({rdata_oe, mem_hit, io_hit, alt_hit, ~wait_n}),
		.o_bus(bus));
	// ----
	// Shared helpers
	// ----
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [10:0] a, input logic [7:0] d);
		u_chmcm_host.cycle(1, a, d);
	endtask
	task automatic rd(input logic [10:0] a, input logic [7:0] m, input logic [7:0] e, input string w);
		u_chmcm_host.cycle(0, a, 8'h00);
		check(w, u_chmcm_host.seen_rdata & m, e);
	endtask
	task automatic wait_irq(input logic lvl);
		int n;
		n = 0;
		while (irq_n !== lvl && n < 30) begin
			tick(1);
			n++;
		end
		check("irq_n", {7'h00, irq_n}, {7'h00, lvl});
		if (irq_n !== lvl)
			finish_test();
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_regs();
		check("static", {4'h0, batt, wp, d8}, 8'h0C);
		check("map", {5'h00, map}, 8'h00);
		rd(11'h200, 8'hFF, 8'h00, "option");
		rd(11'h206, 8'hFF, 8'h00, "socket");
		wr(11'h206, 8'h5A);
		wr(11'h200, 8'h00);
		rd(11'h206, 8'hFF, 8'h5A, "socket");
		rd(11'h204, 8'h20, 8'h20, "pin");
		busy = 1'b1;
		rd(11'h204, 8'h20, 8'h00, "pin busy");
		check("ready", {7'h00, rdy}, 8'h00);
		busy = 1'b0;
		rd(11'h208, 8'hFF, 8'h00, "unmapped");
		$display("test regs done");
	endtask
	task automatic t_modes();
		logic [7:0] opt [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h3F};
		logic [7:0] exp [6] = '{8'h00, 8'h01, 8'h03, 8'h02, 8'h00, 8'h00};
		for (int i = 0; i < 6; i++) begin
			wr(11'h200, opt[i]);
			check("map", {5'h00, map}, exp[i]);
		end
		wr(11'h200, 8'h80);
		check("soft reset", {7'h00, sreset}, 8'h01);
		$display("test modes done");
	endtask
	task automatic t_decode();
		// Option, kind, address, seen bit, then busy and expected hit
		logic [31:0] tb_row [13] = '{32'h00_2_7FF_3_1, 32'h00_0_000_3_0, 32'h00_2_7FF_0_3, 32'h01_3_00F_1_1,
			32'h02_3_1F7_2_1, 32'h02_3_1F8_2_0, 32'h02_3_3F6_1_1, 32'h02_3_3F7_1_1, 32'h02_3_1F0_0_2,
			32'h03_3_170_2_1, 32'h03_3_1F0_2_0, 32'h03_3_376_1_1, 32'h03_3_377_1_1};
		for (int i = 0; i < 13; i++) begin
			wr(11'h200, tb_row[i][31:24]);
			busy = tb_row[i][1];
			u_chmcm_host.cycle(int'(tb_row[i][23:20]), tb_row[i][18:8], 8'h00);
			check("hit", {7'h00, u_chmcm_host.seen[tb_row[i][7:4]]}, {7'h00, tb_row[i][0]});
			busy = 1'b0;
		end
		$display("test decode done");
	endtask
	task automatic t_irq();
		wr(11'h200, 8'h42);
		irq = 1'b1;
		wait_irq(1'b0);
		tick(5);
		check("level", {7'h00, irq_n}, 8'h00);
		rd(11'h202, 8'h02, 8'h02, "pending");
		irq = 1'b0;
		wr(11'h202, 8'h00);
		wr(11'h200, 8'h02);
		irq = 1'b1;
		wait_irq(1'b0);
		tick(1);
		check("pulse", {7'h00, irq_n}, 8'h01);
		irq = 1'b0;
		$display("test irq done");
	endtask
	task automatic t_feat();
		wr(11'h200, 8'h02);
		check("wide", {7'h00, d8}, 8'h00);
		u_chmcm_host.cycle(4, 11'h1F1, 8'h01);
		u_chmcm_host.cycle(4, 11'h1F7, 8'hEF);
		check("byte", {7'h00, d8}, 8'h01);
		u_chmcm_host.cycle(4, 11'h1F1, 8'h81);
		u_chmcm_host.cycle(4, 11'h1F7, 8'hEF);
		check("wide again", {7'h00, d8}, 8'h00);
		$display("test feat done");
	endtask
	task automatic t_tuples();
		logic [10:0] a [6] = '{11'h132, 11'h134, 11'h136, 11'h05E, 11'h060, 11'h133};
		logic [7:0] e [6] = '{8'h14, 8'h00, 8'hFF, 8'h00, 8'h01, 8'h00};
		for (int i = 0; i < 6; i++)
			rd(a[i], 8'hFF, e[i], "tuple");
		$display("test tuples done");
	endtask
	task automatic t_ide();
		int n;
		u_chmcm_host.cycle(4, 11'h1F1, 8'h01);
		u_chmcm_host.cycle(4, 11'h1F7, 8'hEF);
		nrst = 1'b0;
		strap_n = 1'b0;
		tick(10);
		nrst = 1'b1;
		tick(25);
		check("ide", {4'h0, ide, map}, 8'h0E);
		check("ide wide", {7'h00, d8}, 8'h00);
		wr(11'h200, 8'h03);
		u_chmcm_host.cycle(0, 11'h200, 8'h00);
		check("attr oe", {7'h00, u_chmcm_host.seen[4]}, 8'h00);
		check("ide map", {5'h00, map}, 8'h06);
		n = id_cnt;
		u_chmcm_host.cycle(4, 11'h007, 8'hEC);
		check("identify", 8'(id_cnt - n), 8'h01);
		$display("test ide done");
	endtask
	initial begin
		tick(10);
		nrst = 1'b1;
		tick(25);
		t_regs();
		t_modes();
		t_decode();
		t_irq();
		t_feat();
		t_tuples();
		t_ide();
		finish_test();
	end
endmodule
